// File: mwg_pkg.sv
// Constants, register map and types shared by the waveform marker generator
package mwg_pkg;
	localparam int MK_N = 4;
	localparam int PT_W = 4;
	localparam int LEN_W = 5;
	localparam int NPTS = 16;
	localparam int W_N = 2;
	localparam int RT_W = 3;
	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_START = 8'h04;
	localparam logic [7:0] A_END = 8'h08;
	localparam logic [7:0] A_SKIP = 8'h0C;
	localparam logic [7:0] A_POL = 8'h10;
	localparam logic [7:0] A_ROUTE = 8'h14;
	localparam logic [7:0] A_CMD = 8'h18;
	localparam logic [7:0] A_STAT = 8'h1C;
	localparam logic [7:0] A_LEN = 8'h20;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int C_DUAL = 0;
	localparam int C_FMT_ON = 1;
	localparam int C_PLAY = 2;
	localparam int C_SEL = 4;
	localparam int C_EDIT_W = 8;
	localparam int C_PLAY_W = 9;
	localparam int K_FIRST = 0;
	localparam int K_CLEAR = 1;
	localparam int K_APPLY = 2;
	localparam int K_GEN = 3;
	localparam int R_BLANK = 0;
	localparam int R_HOLD = 4;
	localparam int R_ALT = 8;
	localparam int S_BUSY = 0;
	localparam int S_REJ = 1;
	localparam int S_MK = 4;
	localparam int S_POS = 8;
	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [MK_N-1:0] POL_RST = 4'hF;
	localparam logic [LEN_W-1:0] LEN_RST = 5'h10;
	localparam logic [LEN_W-1:0] LEN_MIN = 5'h01;
	localparam logic [MK_N-1:0] GEN_MASK = 4'h3;
	localparam logic [RT_W-1:0] RT_NONE = 3'h0;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {OP_FIRST = 2'h0, OP_CLEAR = 2'h1, OP_APPLY = 2'h2, OP_GEN = 2'h3} edit_op_e;
endpackage

// File: edit_if.sv
// Edit request and memory write path between register block and walker
`timescale 1ns/1ps
interface edit_if;
	logic start;
	mwg_pkg::edit_op_e op;
	logic [mwg_pkg::LEN_W-1:0] len;
	logic [mwg_pkg::PT_W-1:0] first_pt;
	logic [mwg_pkg::PT_W-1:0] last_pt;
	logic [mwg_pkg::PT_W-1:0] skip;
	logic busy;
	logic we;
	logic wbit;
	logic [mwg_pkg::PT_W-1:0] addr;
	modport ctl (output start, op, len, first_pt, last_pt, skip, input busy, we, wbit, addr);
	modport eng (input start, op, len, first_pt, last_pt, skip, output busy, we, wbit, addr);
endinterface

// File: mark_walker.sv
// Walks the points of one waveform and produces the new marker bit for each
`timescale 1ns/1ps
module mark_walker (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Edit channel
	edit_if.eng ed
);
	typedef enum logic [1:0] {S_IDLE = 2'b01, S_WALK = 2'b10} walk_st_e;
	walk_st_e st_q;
	walk_st_e st_d;
	mwg_pkg::edit_op_e op_q;
	logic [mwg_pkg::PT_W-1:0] addr_q;
	logic [mwg_pkg::PT_W-1:0] cnt_q;
	logic [mwg_pkg::PT_W-1:0] cnt_d;
	logic [mwg_pkg::PT_W-1:0] first_q;
	logic [mwg_pkg::PT_W-1:0] last_q;
	logic [mwg_pkg::PT_W-1:0] skip_q;
	logic [mwg_pkg::LEN_W-1:0] len_q;
	logic wbit;
	wire in_rng = (addr_q >= first_q) && (addr_q <= last_q);
	wire hit = in_rng && (cnt_q == '0);
	wire at_end = {1'b0, addr_q} == (len_q - mwg_pkg::LEN_MIN);
	wire walking = (st_q == S_WALK);
	assign ed.busy = walking;
	assign ed.we = walking;
	assign ed.addr = addr_q;
	assign ed.wbit = wbit;
	assign cnt_d = !in_rng ? '0 : (cnt_q == skip_q) ? '0 : cnt_q + 1'b1;
	always_comb
	begin
		unique case (op_q)
			mwg_pkg::OP_FIRST: wbit = (addr_q == '0);
			mwg_pkg::OP_CLEAR: wbit = 1'b0;
			mwg_pkg::OP_APPLY: wbit = hit;
			mwg_pkg::OP_GEN: wbit = (addr_q == '0);
		endcase
	end
	always_comb
	begin
		unique case (st_q)
			S_IDLE: st_d = ed.start ? S_WALK : S_IDLE;
			S_WALK: st_d = at_end ? S_IDLE : S_WALK;
			default: st_d = S_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_q <= S_IDLE;
			op_q <= mwg_pkg::OP_CLEAR;
			addr_q <= '0;
			cnt_q <= '0;
			first_q <= '0;
			last_q <= '0;
			skip_q <= '0;
			len_q <= mwg_pkg::LEN_RST;
		end
		else
		begin
			st_q <= st_d;
			addr_q <= walking ? addr_q + 1'b1 : '0;
			cnt_q <= walking ? cnt_d : '0;
			if (!walking && ed.start)
			begin
				op_q <= ed.op;
				first_q <= ed.first_pt;
				last_q <= ed.last_pt;
				skip_q <= ed.skip;
				len_q <= ed.len;
			end
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	property p_first;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		walking && op_q == mwg_pkg::OP_FIRST |-> wbit == (addr_q == '0);
	endproperty
	a_first: assert property (p_first) else $error("first point edit marks wrong point");
	property p_clear;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		walking && op_q == mwg_pkg::OP_CLEAR |-> !wbit;
	endproperty
	a_clear: assert property (p_clear) else $error("clear edit left a marker");
	property p_range;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		walking && op_q == mwg_pkg::OP_APPLY && wbit |-> addr_q >= first_q && addr_q <= last_q;
	endproperty
	a_range: assert property (p_range) else $error("marker outside range");
	property p_skip;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		walking && op_q == mwg_pkg::OP_APPLY && wbit && skip_q != '0 && !at_end |=> !wbit;
	endproperty
	a_skip: assert property (p_skip) else $error("point after a marked point not skipped");
	property p_skip1;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		walking && op_q == mwg_pkg::OP_APPLY && skip_q == 4'h1 && wbit && !at_end |=> walking && !wbit ##1 (walking && in_rng) |-> wbit;
	endproperty
	a_skip1: assert property (p_skip1) else $error("skip of one is not every other point");
	c_apply: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) walking && op_q == mwg_pkg::OP_APPLY && at_end);
endmodule // mark_walker

// File: waveform_marker_generator.sv
// Four-marker waveform marker generator with AXI4-Lite register access
// Functional notes
// - each marker has its own polarity applied to its output
// - set-first-point marks only point zero for the selected marker
// - clear-all removes all points of the selected marker only
// - range marks start through end, both ends included
// - writing a bound that makes end below start sets end to start
// - skip N marks one point then leaves N points out, repeating
// - range and skip edits reach marker memory only on apply
// - each function routes from one marker or none; none after reset
// - one marker may drive several functions, others different ones
// - level-loop hold holds while routed marker low, releases when high
// - edits target marker one after reset
// - format mode refuses edits until the format is on
// - dual player mode edits any stored waveform
// - generating a waveform marks markers one and two on point zero
// - each marker drives its own numbered event output
// - alternate amplitude engages while routed marker low
// - rf blanking also asserts level-loop hold
`timescale 1ns/1ps
module waveform_marker_generator (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Marker events and level functions
	output logic [mwg_pkg::MK_N-1:0] event_o,
	output logic rf_blank_o,
	output logic level_loop_hold_o,
	output logic alt_amp_o
);
	// ****************************************
	// State
	// ****************************************
	logic dual_q;
	logic fmt_on_q;
	logic play_q;
	logic [1:0] sel_q;
	logic edit_w_q;
	logic play_w_q;
	logic [mwg_pkg::PT_W-1:0] start_q;
	logic [mwg_pkg::PT_W-1:0] end_q;
	logic [mwg_pkg::PT_W-1:0] skip_q;
	logic [mwg_pkg::MK_N-1:0] pol_q;
	logic [mwg_pkg::RT_W-1:0] rt_blank_q;
	logic [mwg_pkg::RT_W-1:0] rt_hold_q;
	logic [mwg_pkg::RT_W-1:0] rt_alt_q;
	logic [mwg_pkg::LEN_W-1:0] len_q;
	logic rej_q;
	logic tgt_w_q;
	logic [mwg_pkg::MK_N-1:0] mask_q;
	logic [mwg_pkg::PT_W-1:0] pos_q;
	logic [mwg_pkg::MK_N-1:0] ev_q;
	logic blank_q;
	logic hold_q;
	logic alt_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [mwg_pkg::MK_N-1:0] mem_q [mwg_pkg::W_N][mwg_pkg::NPTS];
	edit_if ed ();
	mark_walker u_walker (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.ed(ed)
	);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic mapped(input logic [7:0] a);
		mapped = a == mwg_pkg::A_CTRL || a == mwg_pkg::A_START || a == mwg_pkg::A_END
			|| a == mwg_pkg::A_SKIP || a == mwg_pkg::A_POL || a == mwg_pkg::A_ROUTE
			|| a == mwg_pkg::A_CMD || a == mwg_pkg::A_STAT || a == mwg_pkg::A_LEN;
	endfunction
	function automatic logic [31:0] reg_word(input logic [7:0] a);
		logic [31:0] w;
		w = '0;
		unique case (a)
			mwg_pkg::A_CTRL:
			begin
				w[mwg_pkg::C_DUAL] = dual_q;
				w[mwg_pkg::C_FMT_ON] = fmt_on_q;
				w[mwg_pkg::C_PLAY] = play_q;
				w[mwg_pkg::C_SEL +: 2] = sel_q;
				w[mwg_pkg::C_EDIT_W] = edit_w_q;
				w[mwg_pkg::C_PLAY_W] = play_w_q;
			end
			mwg_pkg::A_START: w[mwg_pkg::PT_W-1:0] = start_q;
			mwg_pkg::A_END: w[mwg_pkg::PT_W-1:0] = end_q;
			mwg_pkg::A_SKIP: w[mwg_pkg::PT_W-1:0] = skip_q;
			mwg_pkg::A_POL: w[mwg_pkg::MK_N-1:0] = pol_q;
			mwg_pkg::A_ROUTE:
			begin
				w[mwg_pkg::R_BLANK +: mwg_pkg::RT_W] = rt_blank_q;
				w[mwg_pkg::R_HOLD +: mwg_pkg::RT_W] = rt_hold_q;
				w[mwg_pkg::R_ALT +: mwg_pkg::RT_W] = rt_alt_q;
			end
			mwg_pkg::A_STAT:
			begin
				w[mwg_pkg::S_BUSY] = ed.busy;
				w[mwg_pkg::S_REJ] = rej_q;
				w[mwg_pkg::S_MK +: mwg_pkg::MK_N] = ev_q;
				w[mwg_pkg::S_POS +: mwg_pkg::PT_W] = pos_q;
			end
			mwg_pkg::A_LEN: w[mwg_pkg::LEN_W-1:0] = len_q;
			default: w = '0;
		endcase
		reg_word = w;
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				m[i*8 +: 8] = d[i*8 +: 8];
		merge = m;
	endfunction
	// Routed function is active while its marker output is low
	function automatic logic routed_low(input logic [mwg_pkg::RT_W-1:0] rt, input logic [mwg_pkg::MK_N-1:0] mk);
		logic [1:0] idx;
		idx = 2'(rt - 3'h1);
		routed_low = (rt != mwg_pkg::RT_NONE) && !mk[idx];
	endfunction
	// ****************************************
	// Bus decode
	// ****************************************
	// Write address and data are taken together, so either may arrive first
	wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	wire rd_go = s_axi_arvalid && !rvalid_q;
	// Process form so that a change of any register read back re-merges the word
	logic [31:0] wnew;
	always_comb
		wnew = merge(reg_word(s_axi_awaddr), s_axi_wdata, s_axi_wstrb);
	wire wr_ctrl = wr_go && s_axi_awaddr == mwg_pkg::A_CTRL;
	wire wr_start = wr_go && s_axi_awaddr == mwg_pkg::A_START;
	wire wr_end = wr_go && s_axi_awaddr == mwg_pkg::A_END;
	wire wr_skip = wr_go && s_axi_awaddr == mwg_pkg::A_SKIP;
	wire wr_pol = wr_go && s_axi_awaddr == mwg_pkg::A_POL;
	wire wr_route = wr_go && s_axi_awaddr == mwg_pkg::A_ROUTE;
	wire wr_cmd = wr_go && s_axi_awaddr == mwg_pkg::A_CMD;
	wire wr_stat = wr_go && s_axi_awaddr == mwg_pkg::A_STAT;
	wire wr_len = wr_go && s_axi_awaddr == mwg_pkg::A_LEN;
	wire [mwg_pkg::PT_W-1:0] wpt = wnew[mwg_pkg::PT_W-1:0];
	wire [mwg_pkg::LEN_W-1:0] wlen = wnew[mwg_pkg::LEN_W-1:0];
	wire [mwg_pkg::LEN_W-1:0] wlen_ok = wlen > mwg_pkg::LEN_RST ? mwg_pkg::LEN_RST
		: wlen < mwg_pkg::LEN_MIN ? mwg_pkg::LEN_MIN : wlen;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	// ****************************************
	// Edit launch
	// ****************************************
	// Turning the format on in a control write that leaves dual player off generates the waveform
	wire fmt_rise = wr_ctrl && wnew[mwg_pkg::C_FMT_ON] && !fmt_on_q && !wnew[mwg_pkg::C_DUAL];
	wire cmd_any = wr_cmd && (wnew[mwg_pkg::K_FIRST] || wnew[mwg_pkg::K_CLEAR]
		|| wnew[mwg_pkg::K_APPLY] || wnew[mwg_pkg::K_GEN]);
	wire want = cmd_any || fmt_rise;
	wire allowed = dual_q || fmt_on_q || fmt_rise;
	wire launch = want && allowed && !ed.busy;
	wire refuse = want && !launch;
	mwg_pkg::edit_op_e op_sel;
	assign op_sel = fmt_rise ? mwg_pkg::OP_GEN
		: wnew[mwg_pkg::K_FIRST] ? mwg_pkg::OP_FIRST
		: wnew[mwg_pkg::K_CLEAR] ? mwg_pkg::OP_CLEAR
		: wnew[mwg_pkg::K_APPLY] ? mwg_pkg::OP_APPLY : mwg_pkg::OP_GEN;
	// dual player edits any stored waveform
	wire tgt_w = (dual_q && !fmt_rise) ? edit_w_q : 1'b0;
	// markers one and two on generation
	wire [mwg_pkg::MK_N-1:0] mask_d = op_sel == mwg_pkg::OP_GEN ? mwg_pkg::GEN_MASK
		: mwg_pkg::MK_N'(1) << sel_q;
	assign ed.start = launch;
	assign ed.op = op_sel;
	assign ed.len = len_q;
	assign ed.first_pt = start_q;
	assign ed.last_pt = end_q;
	assign ed.skip = skip_q;
	// ****************************************
	// Playback
	// ****************************************
	wire pos_end = {1'b0, pos_q} >= (len_q - mwg_pkg::LEN_MIN);
	wire [mwg_pkg::MK_N-1:0] raw = play_q ? mem_q[play_w_q][pos_q] : '0;
	wire [mwg_pkg::MK_N-1:0] mk_d = raw ^ ~pol_q;
	// each function decodes its own route
	wire blank_d = routed_low(rt_blank_q, mk_d);
	// hold while routed marker low or blanking
	wire hold_d = routed_low(rt_hold_q, mk_d) || blank_d;
	wire alt_d = routed_low(rt_alt_q, mk_d);
	assign event_o = ev_q;
	assign rf_blank_o = blank_q;
	assign level_loop_hold_o = hold_q;
	assign alt_amp_o = alt_q;
	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			dual_q <= 1'b0;
			fmt_on_q <= 1'b0;
			play_q <= 1'b0;
			sel_q <= 2'h0;
			edit_w_q <= 1'b0;
			play_w_q <= 1'b0;
			pol_q <= mwg_pkg::POL_RST;
			len_q <= mwg_pkg::LEN_RST;
			skip_q <= '0;
			rt_blank_q <= mwg_pkg::RT_NONE;
			rt_hold_q <= mwg_pkg::RT_NONE;
			rt_alt_q <= mwg_pkg::RT_NONE;
		end
		else
		begin
			if (wr_ctrl)
			begin
				dual_q <= wnew[mwg_pkg::C_DUAL];
				fmt_on_q <= wnew[mwg_pkg::C_FMT_ON];
				play_q <= wnew[mwg_pkg::C_PLAY];
				sel_q <= wnew[mwg_pkg::C_SEL +: 2];
				edit_w_q <= wnew[mwg_pkg::C_EDIT_W];
				play_w_q <= wnew[mwg_pkg::C_PLAY_W];
			end
			if (wr_pol)
				pol_q <= wnew[mwg_pkg::MK_N-1:0];
			if (wr_len)
				len_q <= wlen_ok;
			if (wr_skip)
				skip_q <= wpt;
			if (wr_route)
			begin
				rt_blank_q <= wnew[mwg_pkg::R_BLANK +: mwg_pkg::RT_W];
				rt_hold_q <= wnew[mwg_pkg::R_HOLD +: mwg_pkg::RT_W];
				rt_alt_q <= wnew[mwg_pkg::R_ALT +: mwg_pkg::RT_W];
			end
		end
	end
	// end follows start when below it
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			start_q <= '0;
			end_q <= '0;
		end
		else if (wr_start)
		begin
			start_q <= wpt;
			end_q <= end_q < wpt ? wpt : end_q;
		end
		else if (wr_end)
			end_q <= wpt < start_q ? start_q : wpt;
	end
	// Refusal flag: a new refusal wins over a clear in the same cycle
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rej_q <= 1'b0;
		else
			rej_q <= refuse || (rej_q && !(wr_stat && wnew[mwg_pkg::S_REJ]));
	end
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			tgt_w_q <= 1'b0;
			mask_q <= '0;
		end
		else if (launch)
		begin
			tgt_w_q <= tgt_w;
			mask_q <= mask_d;
		end
	end
	// memory changes only through the walker
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int w = 0; w < mwg_pkg::W_N; w++)
				for (int p = 0; p < mwg_pkg::NPTS; p++)
					mem_q[w][p] <= '0;
		end
		else if (ed.we)
			mem_q[tgt_w_q][ed.addr] <= (mem_q[tgt_w_q][ed.addr] & ~mask_q) | (ed.wbit ? mask_q : '0);
	end
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pos_q <= '0;
			ev_q <= mwg_pkg::POL_RST;
			blank_q <= 1'b0;
			hold_q <= 1'b0;
			alt_q <= 1'b0;
		end
		else
		begin
			pos_q <= (!play_q || pos_end) ? '0 : pos_q + 1'b1;
			ev_q <= mk_d;
			blank_q <= blank_d;
			hold_q <= hold_d;
			alt_q <= alt_d;
		end
	end
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= mwg_pkg::RESP_OK;
			rvalid_q <= 1'b0;
			rresp_q <= mwg_pkg::RESP_OK;
			rdata_q <= '0;
		end
		else
		begin
			bvalid_q <= wr_go || (bvalid_q && !s_axi_bready);
			if (wr_go)
				bresp_q <= mapped(s_axi_awaddr) ? mwg_pkg::RESP_OK : mwg_pkg::RESP_SLVERR;
			rvalid_q <= rd_go || (rvalid_q && !s_axi_rready);
			if (rd_go)
			begin
				rdata_q <= reg_word(s_axi_araddr);
				rresp_q <= mapped(s_axi_araddr) ? mwg_pkg::RESP_OK : mwg_pkg::RESP_SLVERR;
			end
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	property p_order;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		end_q >= start_q;
	endproperty
	a_order: assert property (p_order) else $error("range end below start");
	property p_pol;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		play_q && !wr_pol |=> event_o == ($past(raw) ^ ~pol_q);
	endproperty
	a_pol: assert property (p_pol) else $error("event output ignores polarity");
	property p_none;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		rt_alt_q == mwg_pkg::RT_NONE && !wr_route |=> !alt_amp_o;
	endproperty
	a_none: assert property (p_none) else $error("unrouted alternate amplitude engaged");
	property p_alt;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		rt_alt_q != mwg_pkg::RT_NONE && $stable(rt_alt_q) |-> alt_amp_o == !event_o[2'(rt_alt_q - 3'h1)];
	endproperty
	a_alt: assert property (p_alt) else $error("alternate amplitude not tied to low marker");
	property p_hold;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		rf_blank_o |-> level_loop_hold_o;
	endproperty
	a_hold: assert property (p_hold) else $error("blanking without level-loop hold");
	property p_reject;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		cmd_any && !dual_q && !fmt_on_q && !ed.busy |=> !ed.busy && rej_q;
	endproperty
	a_reject: assert property (p_reject) else $error("edit taken while format is off");
	property p_still;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		!ed.we |=> $stable(mem_q[0][0]) && $stable(mem_q[1][0]);
	endproperty
	a_still: assert property (p_still) else $error("marker memory changed without a walk");
	property p_gen;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		launch && fmt_rise |=> mask_q == mwg_pkg::GEN_MASK && ed.busy;
	endproperty
	a_gen: assert property (p_gen) else $error("generation does not target markers one and two");
	c_gen: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) launch && fmt_rise);
	c_alt: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $rose(alt_amp_o));
	c_rej: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) refuse);
endmodule // waveform_marker_generator

// File: event_scope.sv
// Observer instrument recording the four marker event lines
`timescale 1ns/1ps
module event_scope (
	// Clock
	input wire logic ref_clk_i,
	// Event lines and history
	input wire logic [3:0] event_i,
	output logic [63:0] hist_o
);
	// ****
	// Sample history, newest in low nibble
	// ****
	// numbered event lines
	always_ff @(posedge ref_clk_i)
		hist_o <= {hist_o[59:0], event_i};
endmodule // event_scope

// File: waveform_marker_generator_tb.sv
// Random and corner-case bench of the waveform marker generator
`timescale 1ns/1ps
module waveform_marker_generator_tb;
	logic ref_clk_i = 0;
	logic rst_b_i = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 32'h00000000;
	logic awready, wready, bvalid, arready, rvalid, rf_blank, hold, alt;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rv;
	logic [3:0] event_w, pol = 4'hF;
	logic [63:0] hist;
	logic [15:0] mem [2][4] = '{default: 16'h0000};
	integer seed = 59844;
	int mismatches = 0, num_checks = 0, cyc = 0;
	int rb = 0, rh = 0, ra = 0, m, ew, s, e, k, sp = 0;
	waveform_marker_generator i_waveform_marker_generator (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .event_o(event_w), .rf_blank_o(rf_blank), .level_loop_hold_o(hold),
		.alt_amp_o(alt));
	event_scope i_event_scope (.ref_clk_i(ref_clk_i), .event_i(event_w), .hist_o(hist));
	// ****
	// Reporting and bus cycles
	// ****
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge ref_clk_i); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge ref_clk_i); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge ref_clk_i); while (rvalid !== 1'b1);
		rv = rdata;
		rready <= 1'b0;
	endtask
	// Busy lasts the edit length, one point per cycle
	task automatic cmd(input logic [3:0] c);
		wr(mwg_pkg::A_CMD, {28'h0000000, c});
		repeat (20) @(posedge ref_clk_i);
	endtask
	// ****
	// Expectations
	// ****
	function automatic logic [15:0] rng(input int lo, input int hi, input int n);
		rng = 16'h0000;
		for (int p = lo; p <= hi; p += n + 1)
			rng[p] = 1'b1;
	endfunction
	function automatic logic act(input logic [3:0] ev, input int c);
		act = (c != 0) ? !ev[(c - 1) & 3] : 1'b0;
	endfunction
	function automatic logic [3:0] ex(input int w, input int p);
		ex = {mem[w][3][p], mem[w][2][p], mem[w][1][p], mem[w][0][p]} ^ ~pol;
	endfunction
	// Playback matches model at some phase; functions follow routed lines
	task automatic look(input int w);
		logic ok;
		logic hit;
		wr(mwg_pkg::A_CTRL, {22'h0, w[0], ew[0], 2'b00, m[1:0], 4'h7});
		repeat (20)
		begin
			@(negedge ref_clk_i);
			chk(rf_blank, act(event_w, rb));
			chk(hold, act(event_w, rh) | act(event_w, rb));
			chk(alt, act(event_w, ra));
		end
		ok = 1'b0;
		for (int q = 0; q < 16; q++)
		begin
			hit = 1'b1;
			for (int i = 0; i < 16; i++)
				if (hist[4 * i +: 4] !== ex(w, (q - i) & 15))
					hit = 1'b0;
			ok |= hit;
		end
		chk(ok, 1'b1);
	endtask
	// ****
	// Main sequence
	// ****
	initial
		forever #50 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd(mwg_pkg::A_CTRL);
		chk(rv, 32'h0);
		rd(mwg_pkg::A_ROUTE);
		chk(rv, 32'h0);
		rd(mwg_pkg::A_POL);
		chk(rv, 32'hF);
		rd(8'h30);
		chk(rv, 32'h0);
		chk(rresp, mwg_pkg::RESP_SLVERR);
		wr(8'h30, 32'hFFFFFFFF);
		chk(bresp, mwg_pkg::RESP_SLVERR);
		cmd(4'h1);
		rd(mwg_pkg::A_STAT);
		chk(rv[mwg_pkg::S_REJ], 1'b1);
		wr(mwg_pkg::A_CTRL, 32'h6);
		chk(bresp, mwg_pkg::RESP_OK);
		repeat (20) @(posedge ref_clk_i);
		mem[0][0] = 16'h0001;
		mem[0][1] = 16'h0001;
		m = 0;
		ew = 0;
		look(0);
		for (int r = 0; r < 6; r++)
		begin
			m = $random(seed) & 3;
			ew = $random(seed) & 1;
			pol = $random(seed);
			rb = ($random(seed) & 255) % 5;
			rh = ($random(seed) & 255) % 5;
			ra = ($random(seed) & 255) % 5;
			wr(mwg_pkg::A_POL, {28'h0, pol});
			wr(mwg_pkg::A_ROUTE, {21'h0, ra[2:0], 1'b0, rh[2:0], 1'b0, rb[2:0]});
			// Edit a waveform other than the one playing
			wr(mwg_pkg::A_CTRL, {22'h0, ~ew[0], ew[0], 2'b00, m[1:0], 4'h7});
			cmd(4'h2);
			mem[ew][m] = 16'h0000;
			e = $random(seed) & 15;
			s = $random(seed) & 15;
			k = $random(seed) & 3;
			wr(mwg_pkg::A_END, e);
			wr(mwg_pkg::A_START, s);
			wr(mwg_pkg::A_SKIP, k);
			e = (e < sp) ? sp : e;
			e = (e < s) ? s : e;
			sp = s;
			rd(mwg_pkg::A_END);
			chk(rv, e);
			look(ew);
			wr(mwg_pkg::A_CTRL, {22'h0, ~ew[0], ew[0], 2'b00, m[1:0], 4'h7});
			cmd((r & 1) ? 4'h1 : 4'h4);
			mem[ew][m] = (r & 1) ? 16'h0001 : rng(s, e, k);
			look(ew);
		end
		// Generate command in dual mode rewrites markers one and two of the edit waveform
		cmd(4'h8);
		mem[ew][0] = 16'h0001;
		mem[ew][1] = 16'h0001;
		look(ew);
		give_verdict();
	end
endmodule // waveform_marker_generator_tb
